/* rtl/acfs_pkg.sv */
// Package of shared constants and carrier types for the capture sequencer.
package acfs_pkg;

  localparam int ACFS_DATA_W = 16;
  localparam int ACFS_DEPTH = 32768;
  localparam int ACFS_AW = 15;
  localparam int ACFS_MAX_MSPS = 133;
  localparam int ACFS_CLK_MHZ = 100;
  localparam int ACFS_WAKE_WAIT_MS = 30;
  localparam int ACFS_WAKE_WAIT_CYC = ACFS_WAKE_WAIT_MS * 1000 * ACFS_CLK_MHZ;
  localparam int ACFS_RST_PULSE_CYC = 4;
  localparam int ACFS_TRAIL_DELAY_CYC = 1;
  localparam logic [ACFS_AW:0] ACFS_CNT_RESET = 16'h0000;

  typedef enum logic [4:0] {
    ACFS_IDLE = 5'b00001,
    ACFS_RESET = 5'b00010,
    ACFS_FILL = 5'b00100,
    ACFS_WAKE = 5'b01000,
    ACFS_READ = 5'b10000
  } acfs_state_t;

  typedef struct packed {
    logic valid;
    logic [ACFS_DATA_W-1:0] data;
  } acfs_word_t;

  typedef struct packed {
    logic start;
    logic dual;
    logic sel_second;
  } acfs_cmd_t;

endpackage

/* rtl/acfs_skid.sv */
// Two-entry buffer with valid and ready on both sides.
`timescale 1ns/1ps
module acfs_skid #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } acfs_skid_st_t;
  acfs_skid_st_t st, next_st;

  assign in_ready = (st.cnt != 2'h2);
  assign out_valid = (st.cnt != 2'h0);
  assign out_data = st.mem[st.rd];

  always_comb begin
    next_st = st;
    if (in_valid && in_ready) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = ~st.wr;
    end
    if (out_valid && out_ready) begin
      next_st.rd = ~st.rd;
    end
    next_st.cnt = st.cnt + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (rst) st.cnt != 2'h3;
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("buffer count out of range");
endmodule

/* rtl/acfs_top.sv */
// Capture sequencer: fills two sample memories and reads them back.
//
// Behaviour
// - Each channel stores a record of up to 32768 16-bit samples taken at up to 133 MSPS.
// - Two memories can each capture one channel for dual or demultiplexed converters.
// - A fill start first pulses the master reset that clears both memories.
// - When the memories are full their flags drive a wake-up to the microcontroller.
// - Both memories share one 16-bit readback bus selected by their output enables.
// - Readback fetches one selected memory or both in turn in dual mode.
// - In interleaved capture the trailing write enable lags the leading one.
`timescale 1ns/1ps
module acfs_top
  import acfs_pkg::*;
#(
  parameter int DEPTH = acfs_pkg::ACFS_DEPTH,
  parameter int WAKE_WAIT_CYC = acfs_pkg::ACFS_WAKE_WAIT_CYC
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire acfs_pkg::acfs_cmd_t CMD,
  input wire logic WRT_CLK,
  input wire logic [acfs_pkg::ACFS_DATA_W-1:0] ADC_DATA_LEAD,
  input wire logic [acfs_pkg::ACFS_DATA_W-1:0] ADC_DATA_TRAIL,
  output logic FIFO_MASTER_RESET,
  output logic SUSPEND_REQ,
  output logic WAKEUP,
  output logic READY_TO_READ,
  output logic FULL_FIRST,
  output logic FULL_SECOND,
  output logic WRITE_ENABLE_LEADING,
  output logic WRITE_ENABLE_TRAILING,
  output logic READBACK_ENABLE_FIRST,
  output logic READBACK_ENABLE_SECOND,
  output logic RD_VALID,
  input wire logic RD_READY,
  output logic [acfs_pkg::ACFS_DATA_W-1:0] RD_DATA,
  output logic BUSY
);
  import acfs_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [ACFS_DATA_W-1:0] mem_lead [DEPTH];
  logic [ACFS_DATA_W-1:0] mem_trail [DEPTH];

  typedef struct packed {
    acfs_state_t state;
    logic [2:0] wclk_sync;
    logic [1:0][ACFS_DATA_W-1:0] din_s1;
    logic [1:0][ACFS_DATA_W-1:0] din_s2;
    logic [AW:0] wptr_lead;
    logic [AW:0] wptr_trail;
    logic [AW:0] rptr;
    logic rd_second;
    logic dual;
    logic sel_second;
    logic trail_pend;
    logic [31:0] timer;
    logic mrst;
  } acfs_st_t;
  acfs_st_t st, next_st;

  logic wclk_rise;
  logic we_lead;
  logic we_trail;
  logic full_lead;
  logic full_trail;
  logic trail_on;
  logic buf_in_ready;
  logic buf_in_valid;
  logic [ACFS_DATA_W-1:0] rd_word;

  function automatic logic is_full(input logic [AW:0] ptr);
    is_full = (ptr == (AW+1)'(DEPTH));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign wclk_rise = st.wclk_sync[1] && !st.wclk_sync[2];
  assign full_lead = is_full(st.wptr_lead);
  assign full_trail = is_full(st.wptr_trail);
  assign trail_on = st.dual || st.sel_second;
  assign we_lead = (st.state == ACFS_FILL) && wclk_rise && !full_lead;
  assign we_trail = (st.state == ACFS_FILL) && st.trail_pend && trail_on && !full_trail;
  assign buf_in_valid = (st.state == ACFS_READ);
  assign rd_word = st.rd_second ? mem_trail[st.rptr[AW-1:0]] : mem_lead[st.rptr[AW-1:0]];

  always_comb begin
    next_st = st;
    next_st.wclk_sync = {st.wclk_sync[1:0], WRT_CLK};
    next_st.din_s1 = {ADC_DATA_TRAIL, ADC_DATA_LEAD};
    next_st.din_s2 = st.din_s1;
    next_st.trail_pend = we_lead;
    if (we_lead) begin
      next_st.wptr_lead = st.wptr_lead + 1'b1;
    end
    if (we_trail) begin
      next_st.wptr_trail = st.wptr_trail + 1'b1;
    end
    unique case (st.state)
      ACFS_IDLE: begin
        if (CMD.start) begin
          next_st.state = ACFS_RESET;
          next_st.mrst = 1'b1;
          next_st.timer = '0;
          next_st.dual = CMD.dual;
          next_st.sel_second = CMD.sel_second;
        end
      end
      ACFS_RESET: begin
        next_st.wptr_lead = ACFS_CNT_RESET[AW:0];
        next_st.wptr_trail = ACFS_CNT_RESET[AW:0];
        next_st.timer = st.timer + 32'h1;
        if (st.timer == 32'(ACFS_RST_PULSE_CYC - 1)) begin
          next_st.mrst = 1'b0;
          next_st.state = ACFS_FILL;
        end
      end
      ACFS_FILL: begin
        if (full_lead && (full_trail || !trail_on)) begin
          next_st.state = ACFS_WAKE;
          next_st.timer = '0;
        end
      end
      ACFS_WAKE: begin
        next_st.timer = st.timer + 32'h1;
        if (st.timer == 32'(WAKE_WAIT_CYC - 1)) begin
          next_st.state = ACFS_READ;
          next_st.rptr = '0;
          next_st.rd_second = st.sel_second && !st.dual;
        end
      end
      ACFS_READ: begin
        if (buf_in_ready) begin
          next_st.rptr = st.rptr + 1'b1;
          if (st.rptr == (AW+1)'(DEPTH - 1)) begin
            next_st.rptr = '0;
            if (st.dual && !st.rd_second) begin
              next_st.rd_second = 1'b1;
            end else begin
              next_st.state = ACFS_IDLE;
            end
          end
        end
      end
      default: next_st.state = ACFS_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st <= '0;
      st.state <= ACFS_IDLE;
    end else if (CE) begin
      st <= next_st;
    end
  end

  always_ff @(posedge CLK) begin
    if (CE && we_lead) begin
      mem_lead[st.wptr_lead[AW-1:0]] <= st.din_s2[0];
    end
    if (CE && we_trail) begin
      mem_trail[st.wptr_trail[AW-1:0]] <= st.din_s2[1];
    end
  end

  acfs_skid #(
    .WIDTH(ACFS_DATA_W)
  ) u_buf (
    .clk(CLK),
    .rst(SYS_RST),
    .ce(CE),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(rd_word),
    .out_valid(RD_VALID),
    .out_ready(RD_READY),
    .out_data(RD_DATA)
  );

  ////////////////////////////////////////////////////////////////////////////
  assign FIFO_MASTER_RESET = st.mrst;
  assign SUSPEND_REQ = (st.state == ACFS_FILL);
  assign WAKEUP = (st.state == ACFS_WAKE) || (st.state == ACFS_READ);
  assign READY_TO_READ = (st.state == ACFS_READ);
  assign FULL_FIRST = full_lead;
  assign FULL_SECOND = full_trail;
  assign WRITE_ENABLE_LEADING = we_lead;
  assign WRITE_ENABLE_TRAILING = we_trail;
  assign READBACK_ENABLE_FIRST = (st.state == ACFS_READ) && !st.rd_second;
  assign READBACK_ENABLE_SECOND = (st.state == ACFS_READ) && st.rd_second;
  assign BUSY = (st.state != ACFS_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  property p_start_reset;
    @(posedge CLK) disable iff (SYS_RST)
      (CE && st.state == ACFS_IDLE && CMD.start) |=> FIFO_MASTER_RESET;
  endproperty
  a_start_reset: assert property (p_start_reset) else $error("no reset on start");

  property p_reset_no_write;
    @(posedge CLK) disable iff (SYS_RST) FIFO_MASTER_RESET |-> !WRITE_ENABLE_LEADING;
  endproperty
  a_reset_no_write: assert property (p_reset_no_write) else $error("write during reset");

  property p_full_block;
    @(posedge CLK) disable iff (SYS_RST)
      FULL_FIRST |-> !WRITE_ENABLE_LEADING;
  endproperty
  a_full_block: assert property (p_full_block) else $error("write when full");

  property p_full_block_trail;
    @(posedge CLK) disable iff (SYS_RST) FULL_SECOND |-> !WRITE_ENABLE_TRAILING;
  endproperty
  a_full_block_trail: assert property (p_full_block_trail) else $error("trail write when full");

  property p_trail_lags;
    @(posedge CLK) disable iff (SYS_RST)
      WRITE_ENABLE_TRAILING |-> $past(WRITE_ENABLE_LEADING);
  endproperty
  a_trail_lags: assert property (p_trail_lags) else $error("trailing without lead");

  property p_wake;
    @(posedge CLK) disable iff (SYS_RST)
      (CE && SUSPEND_REQ && FULL_FIRST && (FULL_SECOND || !trail_on)) |=> WAKEUP;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake when full");

  property p_oe_excl;
    @(posedge CLK) disable iff (SYS_RST)
      !(READBACK_ENABLE_FIRST && READBACK_ENABLE_SECOND);
  endproperty
  a_oe_excl: assert property (p_oe_excl) else $error("both enables high");

  property p_suspend_fill;
    @(posedge CLK) disable iff (SYS_RST) WRITE_ENABLE_LEADING |-> SUSPEND_REQ && !WAKEUP;
  endproperty
  a_suspend_fill: assert property (p_suspend_fill) else $error("write while awake");

  property p_single_read;
    @(posedge CLK) disable iff (SYS_RST)
      READBACK_ENABLE_SECOND |-> st.dual || st.sel_second;
  endproperty
  a_single_read: assert property (p_single_read) else $error("wrong memory read");

  property p_wait;
    @(posedge CLK) disable iff (SYS_RST)
      $rose(READY_TO_READ) |-> $past(WAKEUP);
  endproperty
  a_wait: assert property (p_wait) else $error("read without wake");
endmodule

/* test/acfs_host_model.sv */
// Host microcontroller model: starts fills and drains the readback stream.
`timescale 1ns/1ps
module acfs_host_model
  import acfs_pkg::*;
(
  input wire logic clk,
  input wire logic req,
  input wire logic dual,
  input wire logic sel_second,
  input wire logic suspended,
  input wire logic reading,
  output acfs_pkg::acfs_cmd_t cmd,
  output logic rd_ready
);
  int seed = 32'h2517e8ec;
  logic req_q;
  initial begin
    cmd = '0;
    rd_ready = 1'b0;
  end
  always @(posedge clk) begin
    // The request is taken at the edge, before the bench moves it.
    req_q = req;
    #1;
    cmd = '{req_q && !suspended, dual, sel_second};
    rd_ready = reading && ($random(seed) % 3 != 0);
  end
endmodule

/* test/tb_top.sv */
// Self-checking testbench for the capture sequencer.
`timescale 1ns/1ps
module tb_top;
  import acfs_pkg::*;
  localparam int D = 16;
  localparam int WW = 20;
  logic CLK = 0, SYS_RST = 1, WRT_CLK = 0, host_req = 0, dual_m = 0, sel_m = 0, run_w = 0;
  logic ce_m = 1;
  logic [15:0] lead = '0, trail = '0, RD_DATA;
  acfs_cmd_t CMD;
  logic FIFO_MASTER_RESET, SUSPEND_REQ, WAKEUP, READY_TO_READ, FULL_FIRST, FULL_SECOND;
  logic WRITE_ENABLE_LEADING, WRITE_ENABLE_TRAILING, READBACK_ENABLE_FIRST;
  logic READBACK_ENABLE_SECOND, RD_VALID, RD_READY, BUSY, prev_lead = 0;
  int seed = 32'h2517e8ec;
  int fails = 0, checked = 0, n_acc, rst_len, n_lead, n_trail;
  logic [15:0] lq[$], tq[$];

  acfs_top #(.DEPTH(D), .WAKE_WAIT_CYC(WW)) acfs_top_inst (.CLK, .SYS_RST, .CE(ce_m), .CMD,
    .WRT_CLK, .ADC_DATA_LEAD(lead), .ADC_DATA_TRAIL(trail), .FIFO_MASTER_RESET, .SUSPEND_REQ,
    .WAKEUP, .READY_TO_READ, .FULL_FIRST, .FULL_SECOND, .WRITE_ENABLE_LEADING,
    .WRITE_ENABLE_TRAILING, .READBACK_ENABLE_FIRST, .READBACK_ENABLE_SECOND, .RD_VALID,
    .RD_READY, .RD_DATA, .BUSY);
  acfs_host_model acfs_host_model_inst (.clk(CLK), .req(host_req), .dual(dual_m),
    .sel_second(sel_m), .suspended(SUSPEND_REQ), .reading(READY_TO_READ | RD_VALID), .cmd(CMD),
    .rd_ready(RD_READY));

  ////////////////////////////////////////////////////////////////////////////////
  always #5 CLK = ~CLK;
  // The sample clock only runs while a fill is framed.
  always begin
    #40;
    WRT_CLK = run_w ? ~WRT_CLK : 1'b0;
  end
  always @(negedge WRT_CLK) begin
    lead = $random(seed);
    trail = dual_m ? $random(seed) : lead;
  end
  always @(posedge WRT_CLK) if (lq.size() < D) begin
    lq.push_back(lead);
    tq.push_back(trail);
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  task automatic final_report;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Outputs are looked at mid-cycle, where they are settled.
  always @(negedge CLK) begin
    if (FIFO_MASTER_RESET) rst_len++;
    if (WRITE_ENABLE_LEADING) n_lead++;
    if (WRITE_ENABLE_TRAILING) n_trail++;
    if ((dual_m || sel_m) && prev_lead) check(WRITE_ENABLE_TRAILING, 1, "trail lag");
    if (WRITE_ENABLE_LEADING) check(SUSPEND_REQ, 1, "write outside fill");
    if (WRITE_ENABLE_LEADING) check(rst_len, ACFS_RST_PULSE_CYC, "write before reset");
    check(READBACK_ENABLE_FIRST & READBACK_ENABLE_SECOND, 0, "both enables");
    if (RD_VALID && RD_READY) begin
      check(RD_DATA, n_acc < D ? lq[n_acc] : tq[n_acc-D], "read data");
      n_acc++;
    end
    prev_lead = WRITE_ENABLE_LEADING;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_for(input int w, output int n);
    n = 0;
    while (!(w == 0 ? SUSPEND_REQ : w == 1 ? WAKEUP : w == 2 ? READY_TO_READ :
             !(BUSY || RD_VALID))) begin
      @(posedge CLK);
      #1;
      n++;
      if (n > 3000) begin
        fails++;
        final_report;
      end
    end
  endtask

  task automatic run(input logic d, input logic s);
    int n;
    dual_m = d;
    sel_m = s;
    lq = {};
    tq = {};
    n_acc = 0;
    rst_len = 0;
    n_lead = 0;
    n_trail = 0;
    host_req = 1;
    @(posedge CLK);
    #1 host_req = 0;
    wait_for(0, n);
    run_w = 1;
    wait_for(1, n);
    run_w = 0;
    host_req = 1;
    @(posedge CLK);
    #1 host_req = 0;
    check(d ? FULL_FIRST & FULL_SECOND : (s ? FULL_SECOND : FULL_FIRST), 1, "full");
    // Three frozen cycles must stretch the wake wait by three.
    ce_m = 0;
    repeat (3) @(posedge CLK);
    #1 ce_m = 1;
    wait_for(2, n);
    check(n, WW - 1, "wake wait");
    wait_for(3, n);
    check(n_acc, d ? 2 * D : D, "word count");
    check(n_lead, D, "stored count");
    if (d || s) check(n_trail, D, "trail count");
    check(rst_len, ACFS_RST_PULSE_CYC, "reset pulse");
    $display("run dual=%0d sel=%0d done", d, s);
  endtask

  initial begin
    repeat (3) @(posedge CLK);
    #1 SYS_RST = 0;
    run(0, 0);
    run(0, 1);
    run(1, 0);
    repeat (2) run($random(seed), $random(seed));
    final_report;
  end
endmodule
